/* hdl/qaw_pkg.sv */
// Shared constants, register map and carrier types for the watchdog.
package qaw_pkg;
  localparam int          CLK_NS       = 10;
  localparam int          TICK_NS      = 1000000;
  localparam int          TICK_CYCLES  = TICK_NS / CLK_NS;
  localparam int          PERIOD_BASE  = 8;
  localparam logic [7:0]  ADR_CFG      = 8'h00;
  localparam logic [7:0]  ADR_QUESTION = 8'h04;
  localparam logic [7:0]  ADR_ANSWER   = 8'h08;
  localparam logic [7:0]  ADR_STATUS   = 8'h0c;
  localparam logic [7:0]  ADR_IRQ_STAT = 8'h10;
  localparam logic [7:0]  ADR_IRQ_EN   = 8'h14;
  localparam int          CFG_PS_LSB   = 0;
  localparam int          CFG_OFF_BIT  = 3;
  localparam int          CFG_DBG_BIT  = 4;
  localparam int          CFG_SEL_BIT  = 5;
  localparam int          ST_FC_LSB    = 0;
  localparam int          ST_FSC_LSB   = 2;
  localparam int          ST_SDM_BIT   = 4;
  localparam int          ST_ACT_BIT   = 5;
  localparam int          ST_WIN_BIT   = 6;
  localparam int          IRQ_PO       = 0;
  localparam int          IRQ_FDE      = 1;
  localparam int          IRQ_WAKE     = 2;
  localparam int          IRQ_SERIAL_FAULT_FLAG     = 3;
  localparam int          IRQ_OTHER    = 4;
  localparam logic [4:0]  IRQ_ALWAYS   = 5'h03;
  localparam logic [4:0]  IRQ_WAKEUP   = 5'h05;
  localparam logic [4:0]  IRQ_EN_RST   = 5'h00;
  localparam logic [1:0]  FC_INIT      = 2'h2;
  localparam logic [1:0]  CNT_MAX      = 2'h3;
  localparam logic [1:0]  FSC_RST      = 2'h0;
  localparam logic [7:0]  QUESTION_RST = 8'h5a;
  localparam logic [7:0]  LFSR_TAPS    = 8'hb8;

  typedef enum logic [2:0] {
    MODE_RESET   = 3'b000,
    MODE_STANDBY = 3'b001,
    MODE_NORMAL  = 3'b010,
    MODE_LISTEN  = 3'b011,
    MODE_SLEEP   = 3'b100
  } qaw_mode_e;

  typedef struct packed {
    logic       irq_select;
    logic       debug_enable;
    logic       supervisor_off;
    logic [2:0] period_select;
  } qaw_cfg_s;

  localparam qaw_cfg_s CFG_RST = '{1'b0, 1'b0, 1'b0, 3'h0};
endpackage : qaw_pkg

/* hdl/qaw_watchdog.sv */
// Question-and-answer watchdog with interrupt capture and Wishbone access.
//
// Overview of operation
// - Standby: timeout mode, answer any time.
// - Period length comes from period select.
// - Normal/ListenOnly: answer only in second half.
// - Standby supervisor off when no irq pending.
// - New irq or answer write re-activates.
// - Valid: inverse answer, no fault, timely.
// - Invalid: wrong, expired, or early in window.
// - Every trigger restarts timer, new question.
// - Fail counter loads 2 leaving Reset.
// - Invalid trigger increments, saturating at 3.
// - Count 3 without debug enters failsafe increment.
// - Development mode only by boot sequence; supervisor idle.
// - Development mode readable as status bit.
// - Outside development mode debug enable only clears.
// - Answer write ends development mode.
// - Debug enable blocks reset process on failures.
// - Standby/Sleep: receive pin low on selected pending irqs.
// - Enables gate sources except power-on, frame-error.
// - Host clears status bits by writing one.
// - Set beats clear in same cycle.
// - Faulted serial message ignored, raises serial fail.
// - Failsafe counter increments per entry, saturates 3.
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
module qaw_watchdog #(
  parameter int TICK_CYCLES = qaw_pkg::TICK_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic [2:0]  dev_mode_i,
  input  wire logic        development_boot_sequence_i,
  input  wire logic        serial_fault_flag_i,
  input  wire logic        power_on_event_i,
  input  wire logic        frame_detect_error_event_i,
  input  wire logic        wake_event_i,
  input  wire logic        other_event_i,
  input  wire logic        can_rx_i,
  output logic             rxd_o,
  output logic             failsafe_increment_state_o
);
  qaw_pkg::qaw_cfg_s cfg_ff;
  qaw_pkg::qaw_mode_e mode;
  logic [2:0]  mode_prev_ff;
  logic [7:0]  question_ff;
  logic [1:0]  fc_ff;
  logic [1:0]  fsc_ff;
  logic        sdm_ff;
  logic [4:0]  irq_stat_ff;
  logic [4:0]  irq_en_ff;
  logic        ack_ff;
  logic [31:0] rdat_ff;
  logic [31:0] tick_cnt_ff;
  logic [10:0] timer_ff;
  logic        fs_ff;

  function automatic logic [10:0] period_ticks(input logic [2:0] ps);
    period_ticks = 11'(qaw_pkg::PERIOD_BASE) << ps;
  endfunction : period_ticks

  function automatic logic [1:0] sat_inc(input logic [1:0] v);
    sat_inc = (v == qaw_pkg::CNT_MAX) ? v : v + 2'h1;
  endfunction : sat_inc

  assign mode = qaw_pkg::qaw_mode_e'(dev_mode_i);

  // Bus decode. A write lands at the same edge that raises ack.
  wire acc      = cyc_i & stb_i & ~ack_ff;
  wire wr       = acc & we_i & sel_i[0];
  wire hit_cfg  = adr_i == qaw_pkg::ADR_CFG;
  wire hit_ans  = adr_i == qaw_pkg::ADR_ANSWER;
  wire hit_stat = adr_i == qaw_pkg::ADR_IRQ_STAT;
  wire hit_en   = adr_i == qaw_pkg::ADR_IRQ_EN;
  wire fault    = wr & serial_fault_flag_i;
  wire wr_ok    = wr & ~serial_fault_flag_i;

  wire leave_reset = (mode_prev_ff == 3'(qaw_pkg::MODE_RESET)) &&
                     (mode != qaw_pkg::MODE_RESET);
  wire standby  = mode == qaw_pkg::MODE_STANDBY;
  wire win_mode = (mode == qaw_pkg::MODE_NORMAL) ||
                  (mode == qaw_pkg::MODE_LISTEN);
  wire sleepish = standby || (mode == qaw_pkg::MODE_SLEEP);
  wire active   = (standby || win_mode) && !sdm_ff &&
                  !cfg_ff.supervisor_off;

  // Interrupt capture.
  wire [4:0] en_eff  = irq_en_ff | qaw_pkg::IRQ_ALWAYS;
  wire [4:0] raw_ev  = {other_event_i, fault, wake_event_i,
                        frame_detect_error_event_i, power_on_event_i};
  wire [4:0] irq_set = raw_ev & en_eff;
  wire [4:0] irq_clr = (wr_ok && hit_stat) ? dat_i[4:0] : 5'h00;
  wire       pending = |irq_stat_ff;
  wire       new_irq = |(irq_set & ~irq_stat_ff);

  // Trigger evaluation.
  wire [10:0] period  = period_ticks(cfg_ff.period_select);
  wire        early   = win_mode && (timer_ff < (period >> 1));
  wire        ans_wr  = wr_ok && hit_ans;
  wire        ans_ok  = dat_i[7:0] == ~question_ff;
  wire        tick    = tick_cnt_ff == 32'(TICK_CYCLES - 1);
  wire        expire  = active && tick && (timer_ff == period - 11'h1);
  wire        ans_act = ans_wr && (standby || win_mode);
  wire        valid   = ans_act && ans_ok && !early;
  wire        invalid = expire || (ans_act && !(ans_ok && !early));
  wire        trigger = valid || invalid;
  wire [1:0]  fc_inc  = sat_inc(fc_ff);
  wire        fs_hit  = invalid && (fc_inc == qaw_pkg::CNT_MAX) &&
                        !cfg_ff.debug_enable;

  wire [7:0] q_next = {question_ff[6:0], ^(question_ff &
                       qaw_pkg::LFSR_TAPS)};

  // Debug enable may be set only inside development mode.
  wire dbg_next = sdm_ff ? dat_i[qaw_pkg::CFG_DBG_BIT]
                         : cfg_ff.debug_enable &
                           dat_i[qaw_pkg::CFG_DBG_BIT];
  wire off_req  = dat_i[qaw_pkg::CFG_OFF_BIT] && standby &&
                  !pending;

  wire [7:0] status = {1'b0, win_mode, active, sdm_ff, fsc_ff, fc_ff};
  wire [7:0] cfg_rd = {2'b00, cfg_ff};
  wire [7:0] rd_mux =
    (adr_i == qaw_pkg::ADR_CFG)      ? cfg_rd :
    (adr_i == qaw_pkg::ADR_QUESTION) ? question_ff :
    (adr_i == qaw_pkg::ADR_STATUS)   ? status :
    (adr_i == qaw_pkg::ADR_IRQ_STAT) ? {3'b000, irq_stat_ff} :
    (adr_i == qaw_pkg::ADR_IRQ_EN)   ? {3'b000, irq_en_ff} : 8'h00;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff  <= acc;
      rdat_ff <= acc ? {24'h00_0000, rd_mux} : 32'h0000_0000;
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = rdat_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_ff <= qaw_pkg::CFG_RST;
    end
    else
    begin
      if (wr_ok && hit_cfg)
      begin
        cfg_ff.period_select <= dat_i[qaw_pkg::CFG_PS_LSB +: 3];
        cfg_ff.irq_select    <= dat_i[qaw_pkg::CFG_SEL_BIT];
        cfg_ff.debug_enable  <= dbg_next;
      end
      else if (!sdm_ff)
      begin
        cfg_ff.debug_enable <= 1'b0;
      end
      if (new_irq || ans_wr)
        cfg_ff.supervisor_off <= 1'b0;
      else if (wr_ok && hit_cfg)
        cfg_ff.supervisor_off <= off_req | (cfg_ff.supervisor_off &
                                 dat_i[qaw_pkg::CFG_OFF_BIT]);
      else if (!standby)
        cfg_ff.supervisor_off <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sdm_ff <= 1'b0;
    end
    else if (ans_wr)
    begin
      sdm_ff <= 1'b0;
    end
    else if (development_boot_sequence_i)
    begin
      sdm_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_stat_ff <= 5'h00;
      irq_en_ff   <= qaw_pkg::IRQ_EN_RST;
    end
    else
    begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
      if (wr_ok && hit_en)
        irq_en_ff <= dat_i[4:0] & ~qaw_pkg::IRQ_ALWAYS;
    end
  end

  // The tick divider free-runs; the period timer restarts on triggers.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || tick)
      tick_cnt_ff <= 32'h0000_0000;
    else
      tick_cnt_ff <= tick_cnt_ff + 32'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || trigger || !active || leave_reset)
      timer_ff <= 11'h000;
    else if (tick)
      timer_ff <= timer_ff + 11'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_prev_ff <= 3'(qaw_pkg::MODE_RESET);
      question_ff  <= qaw_pkg::QUESTION_RST;
      fc_ff        <= qaw_pkg::FC_INIT;
      fsc_ff       <= qaw_pkg::FSC_RST;
      fs_ff        <= 1'b0;
    end
    else
    begin
      mode_prev_ff <= dev_mode_i;
      fs_ff        <= fs_hit;
      if (trigger || leave_reset)
        question_ff <= q_next;
      if (leave_reset)
        fc_ff <= qaw_pkg::FC_INIT;
      else if (invalid)
        fc_ff <= fc_inc;
      if (fs_hit)
        fsc_ff <= sat_inc(fsc_ff);
    end
  end

  assign failsafe_increment_state_o = fs_ff;

  // In Normal or ListenOnly the pin carries bus data instead.
  wire [4:0] rxd_mask = cfg_ff.irq_select ? 5'h1f : qaw_pkg::IRQ_WAKEUP;
  assign rxd_o = sleepish ? ~|(irq_stat_ff & rxd_mask) : can_rx_i;

  sequence s_bad_answer;
    ans_act && !ans_ok;
  endsequence

  sequence s_fc_bumped;
    fc_ff == sat_inc($past(fc_ff));
  endsequence

  fc_init_a: assert property (@(posedge clk_i) disable iff (rst_i)
    leave_reset |=> fc_ff == qaw_pkg::FC_INIT)
    else $error("fail counter not loaded on leaving reset");
  fc_bump_a: assert property (@(posedge clk_i) disable iff (rst_i)
    s_bad_answer and !leave_reset |=> s_fc_bumped)
    else $error("fail counter not advanced on wrong answer");
  fc_sat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fc_ff == qaw_pkg::CNT_MAX && !leave_reset |=> fc_ff == qaw_pkg::CNT_MAX)
    else $error("fail counter left saturation");
  failsafe_go_a: assert property (@(posedge clk_i) disable iff (rst_i)
    invalid && fc_ff >= 2'h2 && !cfg_ff.debug_enable
    |=> failsafe_increment_state_o ##1 !failsafe_increment_state_o[*1])
    else $error("failsafe entry missing or too long");
  debug_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_ff.debug_enable |=> !failsafe_increment_state_o)
    else $error("failsafe entered while debug enabled");
  debug_lock_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !sdm_ff && !cfg_ff.debug_enable |=> !cfg_ff.debug_enable)
    else $error("debug enable set outside development mode");
  sdm_exit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ans_wr |=> !sdm_ff && !cfg_ff.supervisor_off)
    else $error("development mode survived answer write");
  early_bad_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ans_act && win_mode && timer_ff == 11'h000 |-> invalid)
    else $error("early window answer accepted");
  new_question_a: assert property (@(posedge clk_i)
    disable iff (rst_i)
    trigger |=> question_ff != $past(question_ff) && timer_ff == 11'h000)
    else $error("trigger did not refresh question and timer");
  set_wins_a: assert property (@(posedge clk_i) disable iff (rst_i)
    power_on_event_i |=> irq_stat_ff[qaw_pkg::IRQ_PO])
    else $error("power-on event lost");
  off_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    new_irq |=> !cfg_ff.supervisor_off)
    else $error("supervisor stayed off after new interrupt");
  rxd_irq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    sleepish && irq_stat_ff[qaw_pkg::IRQ_WAKE] |-> !rxd_o)
    else $error("receive pin not low on wake interrupt");
endmodule : qaw_watchdog

/* tb/qaw_host_model.sv */
// Wishbone host model with a free-running receive data source.
`timescale 1ns/10ps
module qaw_host_model (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] dat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o,
  output logic             can_rx_o
);
  logic [3:0] lnk_ff = 4'h0;

  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end

  // Toggles every 80 ns, so one link period is 160 ns.
  always @(posedge clk_i)
    lnk_ff <= lnk_ff + 4'h1;
  assign can_rx_o = lnk_ff[3];

  // The request stands until ack is seen at a rising edge.
  task automatic access(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= d;
    @(posedge clk_i);
    while (ack_i !== 1'b1)
      @(posedge clk_i);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
  endtask : access
endmodule : qaw_host_model

/* tb/qaw_watchdog_test.sv */
// Self-checking bench for the question-and-answer watchdog.
`timescale 1ns/10ps
module qaw_watchdog_test;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, ack, can_rx, rxd, fsi;
  logic        boot = 1'b0, sflt = 1'b0, po = 1'b0;
  logic        fde = 1'b0, wake = 1'b0, oth = 1'b0;
  logic [2:0]  mode = 3'h0;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q, r;
  int          bad_count = 0, checked = 0, fs_cnt = 0, ticks = 0;

  initial
    forever #5 clk_i = ~clk_i;

  always @(posedge clk_i)
  begin
    ticks++;
    if (fsi === 1'b1)
      fs_cnt++;
    if (ticks == 5000)
    begin
      bad_count++;
      summarize();
    end
  end

  qaw_host_model u_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel),
    .dat_o(wdat), .can_rx_o(can_rx));

  qaw_watchdog #(.TICK_CYCLES(4)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .dev_mode_i(mode),
    .development_boot_sequence_i(boot), .serial_fault_flag_i(sflt),
    .power_on_event_i(po), .frame_detect_error_event_i(fde),
    .wake_event_i(wake), .other_event_i(oth), .can_rx_i(can_rx),
    .rxd_o(rxd), .failsafe_increment_state_o(fsi));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    u_host.access(1'b1, a, d, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e);
    u_host.access(1'b0, a, 32'h0, r);
    chk(r & m, e);
  endtask : rd

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt

  // Reads the question, then answers it correctly or with its copy.
  task automatic ans(input logic ok);
    u_host.access(1'b0, qaw_pkg::ADR_QUESTION, 32'h0, q);
    wr(qaw_pkg::ADR_ANSWER, {24'h0, ok ? ~q[7:0] : q[7:0]});
  endtask : ans

  task automatic wait_fs(input int n);
    for (int i = 0; i < 200 && fs_cnt < n; i++)
      @(posedge clk_i);
  endtask : wait_fs

  task automatic t_start;
    wt(20);
    rst_i <= 1'b0;
    mode <= qaw_pkg::MODE_STANDBY;
    wr(qaw_pkg::ADR_CFG, 32'h2);
    rd(qaw_pkg::ADR_CFG, 32'hff, 32'h02);
    rd(qaw_pkg::ADR_STATUS, 32'hff, 32'h22);
    rd(qaw_pkg::ADR_IRQ_EN, 32'hff, 32'h0);
    rd(8'h1c, 32'hffffffff, 32'h0);
    ans(1'b1);
    r = q;
    u_host.access(1'b0, qaw_pkg::ADR_QUESTION, 32'h0, q);
    chk(q !== r, 32'h1);
    rd(qaw_pkg::ADR_STATUS, 32'hff, 32'h22);
  endtask : t_start

  task automatic t_expiry;
    wt(100);
    chk(fs_cnt, 0);
    wait_fs(1);
    chk(fs_cnt, 1);
  endtask : t_expiry

  task automatic t_window;
    mode <= qaw_pkg::MODE_NORMAL;
    ans(1'b1);
    wt(2);
    rd(qaw_pkg::ADR_STATUS, 32'hff, 32'h6b);
    wt(60);
    ans(1'b1);
    wt(2);
    chk(fs_cnt, 2);
    #1 chk(rxd, can_rx);
    ans(1'b0);
    wt(2);
    rd(qaw_pkg::ADR_STATUS, 32'hff, 32'h6f);
    wait_fs(4);
    chk(fs_cnt, 4);
    rd(qaw_pkg::ADR_STATUS, 32'hff, 32'h6f);
  endtask : t_window

  task automatic t_dev;
    wr(qaw_pkg::ADR_CFG, 32'h12);
    rd(qaw_pkg::ADR_CFG, 32'h10, 32'h0);
    boot <= 1'b1;
    wt(1);
    boot <= 1'b0;
    rd(qaw_pkg::ADR_STATUS, 32'h30, 32'h10);
    wr(qaw_pkg::ADR_CFG, 32'h12);
    rd(qaw_pkg::ADR_CFG, 32'h10, 32'h10);
    r = fs_cnt;
    wt(150);
    chk(fs_cnt, r);
    ans(1'b1);
    wt(1);
    chk(fs_cnt, r);
    rd(qaw_pkg::ADR_STATUS, 32'h10, 32'h0);
  endtask : t_dev

  task automatic t_irq;
    mode <= qaw_pkg::MODE_STANDBY;
    wr(qaw_pkg::ADR_IRQ_STAT, 32'h1f);
    wr(qaw_pkg::ADR_IRQ_EN, 32'h1f);
    rd(qaw_pkg::ADR_IRQ_EN, 32'hff, 32'h1c);
    wr(qaw_pkg::ADR_IRQ_EN, 32'h0);
    oth <= 1'b1;
    wt(1);
    oth <= 1'b0;
    rd(qaw_pkg::ADR_IRQ_STAT, 32'hff, 32'h0);
    wr(qaw_pkg::ADR_CFG, 32'h0a);
    rd(qaw_pkg::ADR_STATUS, 32'h20, 32'h0);
    fde <= 1'b1;
    wt(1);
    fde <= 1'b0;
    rd(qaw_pkg::ADR_IRQ_STAT, 32'hff, 32'h02);
    rd(qaw_pkg::ADR_CFG, 32'h08, 32'h0);
    rd(qaw_pkg::ADR_STATUS, 32'h20, 32'h20);
    #1 chk(rxd, 1'b1);
    wr(qaw_pkg::ADR_CFG, 32'h2a);
    rd(qaw_pkg::ADR_CFG, 32'h08, 32'h0);
    #1 chk(rxd, 1'b0);
    wr(qaw_pkg::ADR_IRQ_EN, 32'h1c);
    // Wake stands only at the edge that takes the clearing write.
    fork
      wr(qaw_pkg::ADR_IRQ_STAT, 32'h06);
      begin
        @(posedge clk_i);
        wake <= 1'b1;
        @(posedge clk_i);
        wake <= 1'b0;
      end
    join
    rd(qaw_pkg::ADR_IRQ_STAT, 32'hff, 32'h04);
    wr(qaw_pkg::ADR_CFG, 32'h02);
    #1 chk(rxd, 1'b0);
    wr(qaw_pkg::ADR_IRQ_STAT, 32'h04);
    rd(qaw_pkg::ADR_IRQ_STAT, 32'hff, 32'h0);
    ans(1'b1);
    u_host.access(1'b0, qaw_pkg::ADR_QUESTION, 32'h0, q);
    sflt <= 1'b1;
    wr(qaw_pkg::ADR_ANSWER, {24'h0, ~q[7:0]});
    sflt <= 1'b0;
    rd(qaw_pkg::ADR_QUESTION, 32'hff, q);
    rd(qaw_pkg::ADR_IRQ_STAT, 32'hff, 32'h08);
    wr(qaw_pkg::ADR_IRQ_STAT, 32'h1f);
    po <= 1'b1;
    wt(1);
    po <= 1'b0;
    rd(qaw_pkg::ADR_IRQ_STAT, 32'hff, 32'h01);
    #1 chk(rxd, 1'b0);
  endtask : t_irq

  task automatic summarize;
    if (bad_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  initial
  begin
    t_start();
    t_expiry();
    t_window();
    t_dev();
    t_irq();
    summarize();
  end
endmodule : qaw_watchdog_test
